// >>> verilog/fas_pkg.sv
package fas_pkg;
  localparam int FRAC_W = 48;
  localparam int EXP_W = 8;
  localparam int SC_W = 8;
  localparam int SIGN_BIT = 47;
  localparam int TOP_BIT = 46;
  // Exponent code is excess-128; biased zero is the smallest exponent
  localparam logic [EXP_W-1:0] EXCESS = 8'h80;
  localparam logic [EXP_W-1:0] EXP_MIN = 8'h00;
  localparam logic [EXP_W-1:0] EXP_ONE = 8'h01;
  localparam logic [SC_W-1:0] SC_ZERO = 8'h00;
  localparam logic [SC_W-1:0] SC_ONE = 8'h01;
  // Alignment by this many places or more leaves no significant bits
  localparam logic [SC_W-1:0] FAR_LIMIT = 8'h17;
  localparam logic [FRAC_W-1:0] FRAC_ZERO = 48'h0000_0000_0000;
  localparam logic [FRAC_W-1:0] FRAC_ONE = 48'h0000_0000_0001;

  typedef enum logic [2:0] {
    FAS_ALU_ADD,
    FAS_ALU_SUB,
    FAS_ALU_ONE,
    FAS_ALU_DEC
  } fas_alu_op_t;

  typedef enum logic [4:0] {
    FAS_IDLE,
    FAS_SUM,
    FAS_SUM_DECIDE,
    FAS_SUM_SHIFT,
    FAS_OVERFLOW,
    FAS_NOT_LARGER,
    FAS_SMALL_LOAD,
    FAS_SMALL_ALIGN,
    FAS_SMALL_DIFF,
    FAS_SMALL_NORM,
    FAS_KEEP_A,
    FAS_EQ_LOAD,
    FAS_EQ_DIFF,
    FAS_ABS,
    FAS_ZERO,
    FAS_LEFT_NORM,
    FAS_FINAL_COPY,
    FAS_UNDERFLOW,
    FAS_SHARED_SUM,
    FAS_SHARED_DECIDE,
    FAS_SHARED_SHIFT
  } fas_state_t;
endpackage : fas_pkg

// >>> verilog/fas_alu.sv
`timescale 1ns/1ns
`default_nettype none
module fas_alu #(
  parameter int W = fas_pkg::FRAC_W
) (
  input wire fas_pkg::fas_alu_op_t op,
  input wire logic [W-1:0] x,
  input wire logic [W-1:0] y,
  output logic [W-1:0] f,
  output logic f_zero
);
  always_comb begin
    case (op)
      fas_pkg::FAS_ALU_ADD: f = x + y;
      fas_pkg::FAS_ALU_SUB: f = x - y;
      fas_pkg::FAS_ALU_ONE: f = W'(fas_pkg::FRAC_ONE);
      fas_pkg::FAS_ALU_DEC: f = x - W'(fas_pkg::FRAC_ONE);
      default: f = x;
    endcase
  end
  // Null detection watches the ALU output, not the registers
  assign f_zero = (f == '0);
endmodule : fas_alu
`default_nettype wire

// >>> verilog/fas_norm.sv
`timescale 1ns/1ns
`default_nettype none
module fas_norm (
  input wire logic [fas_pkg::FRAC_W-1:0] frac,
  input wire logic [fas_pkg::EXP_W-1:0] exponent,
  output logic [fas_pkg::FRAC_W-1:0] next_frac,
  output logic [fas_pkg::EXP_W-1:0] next_exponent,
  output logic norm_done,
  output logic norm_underflow
);
  // One place per clock; a zero fraction is left alone
  always_comb begin
    norm_done = frac[fas_pkg::TOP_BIT] || (frac == fas_pkg::FRAC_ZERO);
    norm_underflow = !norm_done && (exponent == fas_pkg::EXP_MIN);
    next_frac = {frac[fas_pkg::FRAC_W-2:0], 1'b0};
    next_exponent = exponent - fas_pkg::EXP_ONE;
  end
endmodule : fas_norm
`default_nettype wire

// >>> verilog/fas_seq.sv
// Contract
// - Same signs after alignment: add A and B, sum into both fraction registers.
// - Decision step ends the routine when the sum has no sign-position carry and the null flag is low.
// - Sign overflow branches to a step shifting both fractions right, exponent plus one.
// - Decision step computes exponent plus one; its carry sets the exponent carry flag.
// - Right-shift step loads a one into constant register bit 47.
// - After right shift, end if carry flag low, else go to overflow handler.
// - Overflow handler sets fractions to all ones below the sign bit, exponent to all ones, raises interrupt.
// - Overflow fraction is constant register minus one, via the ALU.
// - Not-larger entry jumps to equal-exponent branch when carry flag is high.
// - Smaller exponent: move MQ into B, null flag low via ALU constant one.
// - Align holds null low; same signs go to shared add, else subtract, normalize.
// - Equal exponents: MQ into B, null low, jump to shared add on same signs.
// - Sign-overflow jump taken on accumulator bit 47 high or null flag high.
// - Unlike signs, equal exponents: A minus B into B, sign flags, flip result sign if A minus B is negative.
// - Next step puts absolute difference in A as constant plus or minus B.
// - Zero difference raises null, jumps to zero handler clearing fraction, exponent, sign.
// - Nonzero difference normalized left; final copy, then underflow handler on underflow.
// - Shared add and decision steps keep the null flag from going high.
// - Underflow handler clears fraction and exponent and raises the interrupt flag.
// - Align shifts B right once per clock, counting down until the count is zero.
// - Exponent register holds excess-128 code.
`timescale 1ns/1ns
`default_nettype none
module fas_seq (
  input wire logic mclk,
  input wire logic rst,
  input wire logic start,
  input wire logic entry_not_larger,
  input wire logic [fas_pkg::FRAC_W-1:0] acc_frac_in,
  input wire logic [fas_pkg::FRAC_W-1:0] multiplier_quotient_reg,
  input wire logic [fas_pkg::EXP_W-1:0] exponent_in,
  input wire logic [fas_pkg::SC_W-1:0] shift_count_in,
  input wire logic exp_carry_in,
  input wire logic result_sign_in,
  input wire logic operand_sign_flag,
  input wire logic irq_clear,
  output logic [fas_pkg::FRAC_W-1:0] frac_a,
  output logic [fas_pkg::FRAC_W-1:0] frac_b,
  output logic [fas_pkg::EXP_W-1:0] exponent,
  output logic [fas_pkg::FRAC_W-1:0] const_reg,
  output logic exp_carry_flag,
  output logic null_flag,
  output logic result_sign_flag,
  output logic diff_pos_flag,
  output logic diff_neg_flag,
  output logic interrupt_flag,
  output logic busy,
  output logic done
);
  ////////////////////////////////////////////////////////////////////////////
  fas_pkg::fas_state_t state;
  fas_pkg::fas_state_t next_state;
  fas_pkg::fas_alu_op_t alu_op;
  logic [fas_pkg::FRAC_W-1:0] alu_x;
  logic [fas_pkg::FRAC_W-1:0] alu_y;
  logic [fas_pkg::FRAC_W-1:0] alu_f;
  logic alu_zero;
  logic [fas_pkg::FRAC_W-1:0] norm_frac;
  logic [fas_pkg::EXP_W-1:0] norm_exp;
  logic norm_done;
  logic norm_uf;
  logic [fas_pkg::SC_W-1:0] shift_count;
  logic [fas_pkg::EXP_W:0] exp_plus;
  logic signs_equal;
  logic sign_overflow;
  logic in_norm;

  fas_alu #(.W(fas_pkg::FRAC_W)) u_alu (
    .op(alu_op),
    .x(alu_x),
    .y(alu_y),
    .f(alu_f),
    .f_zero(alu_zero)
  );

  fas_norm u_norm (
    .frac(frac_a),
    .exponent(exponent),
    .next_frac(norm_frac),
    .next_exponent(norm_exp),
    .norm_done(norm_done),
    .norm_underflow(norm_uf)
  );

  function automatic logic [fas_pkg::FRAC_W-1:0] shr1(
    input logic [fas_pkg::FRAC_W-1:0] v
  );
    shr1 = {1'b0, v[fas_pkg::FRAC_W-1:1]};
  endfunction : shr1

  ////////////////////////////////////////////////////////////////////////////
  // Exponent adder: the carry out flags a maximum exponent
  assign exp_plus = {1'b0, exponent} + {1'b0, fas_pkg::EXP_ONE};
  assign signs_equal = (result_sign_flag == operand_sign_flag);
  assign sign_overflow = frac_a[fas_pkg::SIGN_BIT] || null_flag;
  assign in_norm = (state == fas_pkg::FAS_LEFT_NORM) ||
                   (state == fas_pkg::FAS_SMALL_NORM);
  assign busy = (state != fas_pkg::FAS_IDLE);

  always_comb begin
    alu_op = fas_pkg::FAS_ALU_ADD;
    alu_x = frac_a;
    alu_y = frac_b;
    case (state)
      fas_pkg::FAS_SMALL_LOAD: alu_op = fas_pkg::FAS_ALU_ONE;
      fas_pkg::FAS_EQ_LOAD: alu_op = fas_pkg::FAS_ALU_ONE;
      fas_pkg::FAS_SMALL_DIFF: alu_op = fas_pkg::FAS_ALU_SUB;
      fas_pkg::FAS_EQ_DIFF: alu_op = fas_pkg::FAS_ALU_SUB;
      fas_pkg::FAS_ABS: begin
        alu_x = const_reg;
        alu_op = diff_neg_flag ? fas_pkg::FAS_ALU_SUB
                               : fas_pkg::FAS_ALU_ADD;
      end
      fas_pkg::FAS_OVERFLOW: begin
        alu_x = const_reg;
        alu_op = fas_pkg::FAS_ALU_DEC;
      end
      default: alu_op = fas_pkg::FAS_ALU_ADD;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Every branch below reads registered flags only, so a flag that a
  // step updates as it ends cannot steer that same step's jump
  always_comb begin
    next_state = state;
    case (state)
      fas_pkg::FAS_IDLE: begin
        if (start) begin
          next_state = entry_not_larger ? fas_pkg::FAS_NOT_LARGER
                                        : fas_pkg::FAS_SUM;
        end
      end
      fas_pkg::FAS_SUM: next_state = fas_pkg::FAS_SUM_DECIDE;
      fas_pkg::FAS_SUM_DECIDE: begin
        next_state = sign_overflow ? fas_pkg::FAS_SUM_SHIFT
                                   : fas_pkg::FAS_IDLE;
      end
      fas_pkg::FAS_SUM_SHIFT, fas_pkg::FAS_SHARED_SHIFT: begin
        next_state = exp_carry_flag ? fas_pkg::FAS_OVERFLOW
                                    : fas_pkg::FAS_IDLE;
      end
      fas_pkg::FAS_OVERFLOW: next_state = fas_pkg::FAS_IDLE;
      fas_pkg::FAS_NOT_LARGER: begin
        next_state = exp_carry_flag ? fas_pkg::FAS_EQ_LOAD
                                    : fas_pkg::FAS_SMALL_LOAD;
      end
      fas_pkg::FAS_SMALL_LOAD: begin
        next_state = exp_carry_flag ? fas_pkg::FAS_KEEP_A
                                    : fas_pkg::FAS_SMALL_ALIGN;
      end
      fas_pkg::FAS_SMALL_ALIGN: begin
        // Step is stretched until the count runs out
        if (shift_count == fas_pkg::SC_ZERO) begin
          next_state = signs_equal ? fas_pkg::FAS_SHARED_SUM
                                   : fas_pkg::FAS_SMALL_DIFF;
        end
      end
      fas_pkg::FAS_SMALL_DIFF: next_state = fas_pkg::FAS_SMALL_NORM;
      fas_pkg::FAS_SMALL_NORM, fas_pkg::FAS_LEFT_NORM: begin
        if (norm_done || norm_uf) begin
          next_state = fas_pkg::FAS_FINAL_COPY;
        end
      end
      fas_pkg::FAS_KEEP_A: next_state = fas_pkg::FAS_IDLE;
      fas_pkg::FAS_EQ_LOAD: begin
        next_state = signs_equal ? fas_pkg::FAS_SHARED_SUM
                                 : fas_pkg::FAS_EQ_DIFF;
      end
      fas_pkg::FAS_EQ_DIFF: next_state = fas_pkg::FAS_ABS;
      fas_pkg::FAS_ABS: begin
        next_state = null_flag ? fas_pkg::FAS_ZERO
                               : fas_pkg::FAS_LEFT_NORM;
      end
      fas_pkg::FAS_ZERO: next_state = fas_pkg::FAS_IDLE;
      fas_pkg::FAS_FINAL_COPY: begin
        next_state = exp_carry_flag ? fas_pkg::FAS_UNDERFLOW
                                    : fas_pkg::FAS_IDLE;
      end
      fas_pkg::FAS_UNDERFLOW: next_state = fas_pkg::FAS_IDLE;
      fas_pkg::FAS_SHARED_SUM: next_state = fas_pkg::FAS_SHARED_DECIDE;
      fas_pkg::FAS_SHARED_DECIDE: begin
        next_state = sign_overflow ? fas_pkg::FAS_SHARED_SHIFT
                                   : fas_pkg::FAS_IDLE;
      end
      default: next_state = fas_pkg::FAS_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= fas_pkg::FAS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      done <= 1'b0;
    end else begin
      done <= busy && (next_state == fas_pkg::FAS_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator fraction A
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      frac_a <= fas_pkg::FRAC_ZERO;
    end else begin
      case (state)
        fas_pkg::FAS_IDLE: if (start) frac_a <= acc_frac_in;
        fas_pkg::FAS_SUM, fas_pkg::FAS_SHARED_SUM: frac_a <= alu_f;
        fas_pkg::FAS_SUM_SHIFT, fas_pkg::FAS_SHARED_SHIFT: begin
          frac_a <= shr1(frac_a);
        end
        fas_pkg::FAS_OVERFLOW: frac_a <= alu_f;
        fas_pkg::FAS_SMALL_DIFF: frac_a <= alu_f;
        fas_pkg::FAS_ABS: frac_a <= alu_f;
        fas_pkg::FAS_SMALL_NORM, fas_pkg::FAS_LEFT_NORM: begin
          if (!norm_done && !norm_uf) frac_a <= norm_frac;
        end
        fas_pkg::FAS_ZERO, fas_pkg::FAS_UNDERFLOW: begin
          frac_a <= fas_pkg::FRAC_ZERO;
        end
        default: frac_a <= frac_a;
      endcase
    end
  end

  // Second fraction B
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      frac_b <= fas_pkg::FRAC_ZERO;
    end else begin
      case (state)
        fas_pkg::FAS_IDLE: if (start) frac_b <= acc_frac_in;
        fas_pkg::FAS_SUM, fas_pkg::FAS_SHARED_SUM: frac_b <= alu_f;
        fas_pkg::FAS_SUM_SHIFT, fas_pkg::FAS_SHARED_SHIFT: begin
          frac_b <= shr1(frac_b);
        end
        fas_pkg::FAS_OVERFLOW: frac_b <= alu_f;
        fas_pkg::FAS_SMALL_LOAD, fas_pkg::FAS_EQ_LOAD: begin
          frac_b <= multiplier_quotient_reg;
        end
        fas_pkg::FAS_SMALL_ALIGN: begin
          if (shift_count != fas_pkg::SC_ZERO) begin
            frac_b <= shr1(frac_b);
          end
        end
        fas_pkg::FAS_EQ_DIFF: frac_b <= alu_f;
        fas_pkg::FAS_KEEP_A, fas_pkg::FAS_FINAL_COPY: frac_b <= frac_a;
        fas_pkg::FAS_ZERO, fas_pkg::FAS_UNDERFLOW: begin
          frac_b <= fas_pkg::FRAC_ZERO;
        end
        default: frac_b <= frac_b;
      endcase
    end
  end

  // Exponent, biased
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      exponent <= fas_pkg::EXCESS;
    end else begin
      case (state)
        fas_pkg::FAS_IDLE: if (start) exponent <= exponent_in;
        fas_pkg::FAS_SUM_SHIFT, fas_pkg::FAS_SHARED_SHIFT: begin
          exponent <= exp_plus[fas_pkg::EXP_W-1:0];
        end
        fas_pkg::FAS_OVERFLOW: exponent <= '1;
        fas_pkg::FAS_SMALL_NORM, fas_pkg::FAS_LEFT_NORM: begin
          if (!norm_done && !norm_uf) exponent <= norm_exp;
        end
        fas_pkg::FAS_ZERO, fas_pkg::FAS_UNDERFLOW: begin
          exponent <= fas_pkg::EXP_MIN;
        end
        default: exponent <= exponent;
      endcase
    end
  end

  // Shift counter
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      shift_count <= fas_pkg::SC_ZERO;
    end else if (state == fas_pkg::FAS_IDLE) begin
      if (start) shift_count <= shift_count_in;
    end else if (state == fas_pkg::FAS_SMALL_ALIGN &&
                 shift_count != fas_pkg::SC_ZERO) begin
      shift_count <= shift_count - fas_pkg::SC_ONE;
    end
  end

  // Constant register: cleared on entry so the absolute step sees zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      const_reg <= fas_pkg::FRAC_ZERO;
    end else if (state == fas_pkg::FAS_IDLE) begin
      if (start) const_reg <= fas_pkg::FRAC_ZERO;
    end else if (state == fas_pkg::FAS_SUM_SHIFT ||
                 state == fas_pkg::FAS_SHARED_SHIFT) begin
      const_reg[fas_pkg::SIGN_BIT] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Exponent carry flag
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      exp_carry_flag <= 1'b0;
    end else begin
      case (state)
        fas_pkg::FAS_IDLE: if (start) exp_carry_flag <= exp_carry_in;
        fas_pkg::FAS_SUM_DECIDE, fas_pkg::FAS_SHARED_DECIDE: begin
          exp_carry_flag <= exp_plus[fas_pkg::EXP_W];
        end
        fas_pkg::FAS_NOT_LARGER: begin
          exp_carry_flag <= (shift_count >= fas_pkg::FAR_LIMIT);
        end
        fas_pkg::FAS_SMALL_NORM, fas_pkg::FAS_LEFT_NORM: begin
          exp_carry_flag <= norm_uf;
        end
        default: exp_carry_flag <= exp_carry_flag;
      endcase
    end
  end

  // Null flag takes the ALU zero test in sum, load and equal-exponent difference steps; align and shared steps hold it low
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      null_flag <= 1'b0;
    end else begin
      case (state)
        fas_pkg::FAS_SUM: null_flag <= alu_zero;
        fas_pkg::FAS_SMALL_LOAD, fas_pkg::FAS_EQ_LOAD: begin
          null_flag <= alu_zero;
        end
        fas_pkg::FAS_SMALL_ALIGN: null_flag <= 1'b0;
        // Two zero operands would otherwise fake a sign overflow
        fas_pkg::FAS_SHARED_SUM, fas_pkg::FAS_SHARED_DECIDE: begin
          null_flag <= 1'b0;
        end
        fas_pkg::FAS_EQ_DIFF: null_flag <= alu_zero;
        default: null_flag <= null_flag;
      endcase
    end
  end

  // Sign of result and sign of difference
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      result_sign_flag <= 1'b0;
      diff_pos_flag <= 1'b0;
      diff_neg_flag <= 1'b0;
    end else begin
      case (state)
        fas_pkg::FAS_IDLE: begin
          if (start) begin
            result_sign_flag <= result_sign_in;
            diff_pos_flag <= 1'b0;
            diff_neg_flag <= 1'b0;
          end
        end
        fas_pkg::FAS_EQ_DIFF: begin
          diff_pos_flag <= !alu_f[fas_pkg::SIGN_BIT];
          diff_neg_flag <= alu_f[fas_pkg::SIGN_BIT];
          if (alu_f[fas_pkg::SIGN_BIT]) begin
            result_sign_flag <= !result_sign_flag;
          end
        end
        fas_pkg::FAS_ZERO: result_sign_flag <= 1'b0;
        default: result_sign_flag <= result_sign_flag;
      endcase
    end
  end

  // Interrupt flag: a new event wins over a clear in the same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      interrupt_flag <= 1'b0;
    end else if (state == fas_pkg::FAS_OVERFLOW ||
                 state == fas_pkg::FAS_UNDERFLOW) begin
      interrupt_flag <= 1'b1;
    end else if (irq_clear) begin
      interrupt_flag <= 1'b0;
    end
  end

  // Norm steps never sit idle: in_norm feeds only unused_norm and steers no logic
  logic unused_norm;
  assign unused_norm = in_norm;
endmodule : fas_seq
`default_nettype wire

// >>> verif/fas_seq_sva.sv
`timescale 1ns/1ns
`default_nettype none
module fas_seq_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic start,
  input wire logic entry_not_larger,
  input wire logic [fas_pkg::FRAC_W-1:0] acc_frac_in,
  input wire logic [fas_pkg::FRAC_W-1:0] multiplier_quotient_reg,
  input wire logic [fas_pkg::EXP_W-1:0] exponent_in,
  input wire logic result_sign_in,
  input wire logic operand_sign_flag,
  input wire logic [fas_pkg::FRAC_W-1:0] frac_a,
  input wire logic [fas_pkg::FRAC_W-1:0] frac_b,
  input wire logic [fas_pkg::EXP_W-1:0] exponent,
  input wire logic [fas_pkg::FRAC_W-1:0] const_reg,
  input wire logic exp_carry_flag,
  input wire logic null_flag,
  input wire logic result_sign_flag,
  input wire logic interrupt_flag,
  input wire logic busy,
  input wire logic done
);
  ////////////////////////////////////////////////////////////////////////////
  // Operands as taken, so later steps can be judged against them
  logic [fas_pkg::FRAC_W-1:0] acc_q;
  logic [fas_pkg::EXP_W-1:0] exp_q;
  logic nl_q;
  logic sign_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc_q <= 48'h0;
      exp_q <= 8'h00;
      nl_q <= 1'b0;
      sign_q <= 1'b0;
    end else if (start && !busy) begin
      acc_q <= acc_frac_in;
      exp_q <= exponent_in;
      nl_q <= entry_not_larger;
      sign_q <= result_sign_in;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_take;
    start && !busy;
  endsequence
  sequence s_sum;
    start && !busy && !entry_not_larger;
  endsequence

  AST_BUSY_TAKE: assert property (s_take |=> busy)
    else $error("busy did not rise after start");
  AST_DONE_ONE: assert property (done |-> !busy ##1 !done)
    else $error("done not a one cycle idle pulse");
  AST_SUM: assert property (s_sum |-> ##2
    (frac_a == {acc_q[46:0], 1'b0} && frac_b == frac_a))
    else $error("sum not written to both fractions");
  AST_SUM_END: assert property (s_sum ##2 (!frac_a[47] && !null_flag)
    |-> ##1 (done && !busy))
    else $error("normalized sum did not end routine");
  AST_SUM_SHIFT: assert property (s_sum ##2
    ((frac_a[47] || null_flag) && exp_q != 8'hff) |-> ##2
    (frac_a == {1'b0, acc_q[46:0]} && frac_b == frac_a &&
     exponent == exp_q + 8'h01 && const_reg == 48'h8000_0000_0000 && done))
    else $error("right shift correction wrong");
  AST_CARRY: assert property (s_sum ##2 (frac_a[47] || null_flag)
    |-> ##1 (exp_carry_flag == (exp_q == 8'hff)))
    else $error("exponent carry flag wrong at decision");
  AST_OVERFLOW: assert property (s_sum ##2
    (frac_a[47] && exp_q == 8'hff) |-> ##3
    (frac_a == 48'h7fff_ffff_ffff && frac_b == frac_a &&
     exponent == 8'hff && interrupt_flag && done))
    else $error("overflow saturation wrong");
  AST_LOAD_B: assert property (s_take ##0 entry_not_larger |-> ##3
    (frac_b == multiplier_quotient_reg && !null_flag))
    else $error("new fraction not moved to B with null low");
  AST_ZERO: assert property (busy && nl_q && $rose(null_flag) |-> ##2
    (frac_a == 48'h0 && frac_b == 48'h0 && exponent == 8'h00 &&
     !result_sign_flag))
    else $error("zero difference not cleaned");
  AST_SHARED_NULL: assert property ($past(busy, 2) && busy && nl_q &&
    operand_sign_flag == sign_q |-> !null_flag)
    else $error("null flag rose in shared add");
endmodule : fas_seq_chk

bind fas_seq fas_seq_chk fas_seq_chk_i (.mclk(mclk), .rst(rst),
  .start(start), .entry_not_larger(entry_not_larger),
  .acc_frac_in(acc_frac_in), .multiplier_quotient_reg(multiplier_quotient_reg),
  .exponent_in(exponent_in), .result_sign_in(result_sign_in),
  .operand_sign_flag(operand_sign_flag), .frac_a(frac_a), .frac_b(frac_b),
  .exponent(exponent), .const_reg(const_reg),
  .exp_carry_flag(exp_carry_flag), .null_flag(null_flag),
  .result_sign_flag(result_sign_flag), .interrupt_flag(interrupt_flag),
  .busy(busy), .done(done));
`default_nettype wire

// >>> verif/fas_seq_test.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, xp, got) begin tests_run++; if ((got) !== (xp)) begin \
  n_fail++; $display("MISMATCH %s expected %h seen %h", nm, xp, got); end end
module fas_seq_test;
  logic mclk, rst, start, nl, ec, rs, os, clr;
  logic [47:0] acc, mq, fa, fb, cr, ex_f, r1, r2;
  logic [7:0] e, sc, eo, ex_e;
  logic ecf, nf, rsf, dp, dn, irq, busy, done;
  logic ex_s, ex_i, ex_c, ex_n;
  logic [15:0] lfsr = 16'h8959;
  int n_fail, tests_run, ex_k;

  fas_seq fas_seq_i (.mclk(mclk), .rst(rst), .start(start),
    .entry_not_larger(nl), .acc_frac_in(acc), .multiplier_quotient_reg(mq),
    .exponent_in(e), .shift_count_in(sc), .exp_carry_in(ec),
    .result_sign_in(rs), .operand_sign_flag(os), .irq_clear(clr),
    .frac_a(fa), .frac_b(fb), .exponent(eo), .const_reg(cr),
    .exp_carry_flag(ecf), .null_flag(nf), .result_sign_flag(rsf),
    .diff_pos_flag(dp), .diff_neg_flag(dn), .interrupt_flag(irq),
    .busy(busy), .done(done));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [47:0] rnd();
    logic [47:0] r;
    r = 48'h0;
    repeat (48) begin
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      r = {r[46:0], lfsr[0]};
    end
    return r;
  endfunction : rnd

  // Reference result of one routine
  task automatic predict(input logic n, c, s1, s2, input logic [47:0] a, m,
                         input logic [7:0] x, s);
    logic [47:0] bb;
    ex_e = x;
    ex_s = s1;
    ex_i = 1'b0;
    ex_c = 1'b0;
    ex_n = 1'b0;
    ex_k = 3;
    bb = !n ? a : (c ? m : m >> s);
    // Smaller operand too far down to matter: A is kept as it stands
    if (n && !c && s >= fas_pkg::FAR_LIMIT) begin
      ex_f = a;
    end else if (!n || s1 == s2) begin
      ex_f = a + bb;
      if (ex_f[47] || (!n && ex_f == 48'h0)) begin
        ex_c = 1'b1;
        ex_k = 4;
        if (x == 8'hff) begin
          ex_f = 48'h7fff_ffff_ffff;
          ex_i = 1'b1;
          ex_k = 5;
        end else begin
          ex_f = ex_f >> 1;
          ex_e = x + 8'h01;
        end
      end
    end else begin
      ex_f = a - bb;
      ex_n = ex_f[47];
      if (ex_n) begin
        ex_f = -ex_f;
        ex_s = !s1;
      end
      if (ex_f == 48'h0) begin
        ex_e = 8'h00;
        ex_s = 1'b0;
      end
      while (ex_f != 48'h0 && !ex_f[46]) begin
        if (ex_e == 8'h00) begin
          ex_f = 48'h0;
          ex_i = 1'b1;
        end else begin
          ex_f = ex_f << 1;
          ex_e = ex_e - 8'h01;
        end
      end
    end
  endtask : predict

  // A second start mid-routine and a changed operand must both be ignored
  task automatic run(input logic n, c, input logic [47:0] a, m,
                     input logic [7:0] x, s, input logic s1, s2);
    int k;
    predict(n, c, s1, s2, a, m, x, s);
    @(negedge mclk);
    nl = n;
    ec = c;
    acc = a;
    mq = m;
    e = x;
    sc = s;
    rs = s1;
    os = s2;
    clr = 1'b1;
    start = 1'b1;
    k = 0;
    do begin
      @(negedge mclk);
      k++;
      start = (k == 2);
      clr = 1'b0;
      acc = ~a;
    end while (!done && k < 300);
    `CHK("done", 1'b1, done)
    if (!n) `CHK("cycles", ex_k, k)
    `CHK("frac_a", ex_f, fa)
    `CHK("frac_b", ex_f, fb)
    `CHK("exponent", ex_e, eo)
    `CHK("sign", ex_s, rsf)
    `CHK("irq", ex_i, irq)
    `CHK("const", {ex_c, 47'h0}, cr)
    if (n && c && s1 != s2) `CHK("neg", ex_n, dn)
    if (n && c && s1 != s2) `CHK("pos", !ex_n, dp)
    $display("test end mode %0d%0d", n, c);
    repeat (2) @(negedge mclk);
  endtask : run

  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    #200000;
    n_fail++;
    stop_test;
  end

  initial begin
    {rst, start, nl, ec, rs, os, clr} = 7'h41;
    {acc, mq, e, sc} = 112'h0;
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    run(0, 0, 48'h3000_0000_0000, 48'h0, 8'h83, 8'h00, 0, 0);
    run(0, 0, 48'h7000_0000_0000, 48'h0, 8'h83, 8'h00, 1, 1);
    run(0, 0, 48'h4000_0000_0001, 48'h0, 8'hff, 8'h00, 0, 0);
    run(0, 0, 48'h0, 48'h0, 8'h90, 8'h00, 0, 0);
    run(1, 1, 48'h4000_0000_0000, 48'h4000_0000_0000, 8'h85, 8'h00, 0, 0);
    run(1, 1, 48'h0, 48'h0, 8'h85, 8'h00, 1, 1);
    run(1, 1, 48'h5000_0000_0000, 48'h5000_0000_0000, 8'h85, 8'h00, 1, 0);
    run(1, 1, 48'h4000_0000_0000, 48'h6000_0000_0000, 8'h85, 8'h00, 0, 1);
    run(1, 1, 48'h4000_0000_0001, 48'h4000_0000_0000, 8'h00, 8'h00, 0, 1);
    run(1, 0, 48'h4000_0000_0000, 48'h7fff_0000_0000, 8'h81, 8'h01, 0, 1);
    run(1, 0, 48'h7fff_ffff_ffff, 48'h7fff_ffff_ffff, 8'hff, 8'h01, 0, 0);
    run(1, 0, 48'h4000_0000_0000, 48'h4000_0000_0000, 8'h81, 8'h14, 1, 1);
    run(1, 0, 48'h4000_0000_0000, 48'h7fff_0000_0000, 8'h81, 8'h17, 0, 1);
    run(1, 0, 48'h5000_0000_0000, 48'h4000_0000_0000, 8'h90, 8'h18, 1, 1);
    repeat (60) begin
      r1 = rnd();
      r2 = rnd();
      if (r2[47:46] == 2'b00)
        run(0, 0, {1'b0, r1[46:0]}, r2, r2[17:10], 8'h00, r2[9], r2[9]);
      else
        run(1, r2[46], {2'b01, r1[45:0]}, {2'b01, r2[45:0]}, r2[17:10],
            {4'h0, r2[3:0]} + 8'h01, r2[8], r2[9]);
    end
    stop_test;
  end
endmodule : fas_seq_test
`default_nettype wire
